//--- shared/hscfg_pkg.sv
// Constants and types for the hub string and port configuration register bank.
// Assumes an 8-bit register port with byte addresses, driven from the core clock.
// Summary of operation
// - Serial string bytes, UTF-16LE, low byte first.
// - Charge enable bit1 port one, bit2 port two.
// - Upstream boost code sits in bits 1:0.
// - Port two boost code sits in bits 3:2.
// - Port one boost code sits in bits 1:0.
// - Boost codes forwarded: normal, +4, +8, +12 percent.
// - Swap bit0 upstream, bit1 port one, bit2 two.
// - Upstream swap set moves D+ to DM, D- to DP; port swap bits are only forwarded.
package hscfg_pkg;
	localparam logic [7:0] SERIAL_FIRST_OFS  = 8'h92;
	localparam logic [7:0] SERIAL_LAST_OFS   = 8'hCF;
	localparam int         SERIAL_BYTES      = 62;
	localparam logic [7:0] CHARGE_EN_OFS     = 8'hD0;
	localparam logic [7:0] UP_BOOST_OFS      = 8'hF6;
	localparam logic [7:0] DN_BOOST_OFS      = 8'hF8;
	localparam logic [7:0] PIN_SWAP_OFS      = 8'hFA;
	localparam logic [7:0] REG_RESET_VAL     = 8'h00;
	localparam logic [7:0] CHARGE_EN_MASK    = 8'h06;
	localparam logic [7:0] UP_BOOST_MASK     = 8'h03;
	localparam logic [7:0] DN_BOOST_MASK     = 8'h0F;
	localparam logic [7:0] PIN_SWAP_MASK     = 8'h07;
	localparam int         CHARGE_P1_BIT     = 1;
	localparam int         CHARGE_P2_BIT     = 2;
	localparam int         SWAP_UP_BIT       = 0;
	localparam int         SWAP_P1_BIT       = 1;
	localparam int         SWAP_P2_BIT       = 2;
	localparam int         BOOST_P1_LSB      = 0;
	localparam int         BOOST_P2_LSB      = 2;
	localparam int         UP_BOOST_LSB      = 0;

	typedef enum logic [1:0] {
		HSCFG_BOOST_NORMAL,
		HSCFG_BOOST_PLUS4,
		HSCFG_BOOST_PLUS8,
		HSCFG_BOOST_PLUS12
	} hscfg_boost_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} hscfg_req_t;

	typedef struct packed {
		hscfg_boost_t upstream_boost_code;
		hscfg_boost_t port_one_boost_code;
		hscfg_boost_t port_two_boost_code;
		logic [1:0]   charge_en;
		logic [2:0]   swap;
	} hscfg_port_cfg_t;
endpackage

//--- hw/hscfg_regs.sv
// Register bank holding the serial string bytes and the per-port drive configuration.
// Assumes a same-clock register port: one access per cycle, read data valid next cycle.
`timescale 1ns/1ps
module hscfg_regs (
	// Clock and reset
	input  wire logic                      sys_clk_i,
	input  wire logic                      rst_i,
	// Register port
	input  wire hscfg_pkg::hscfg_req_t     req_i,
	output logic [7:0]                     rdata_o,
	output logic                           rvalid_o,
	// Serial string read port for the descriptor engine
	input  wire logic [5:0]                str_idx_i,
	output logic [7:0]                     str_byte_o,
	// Port configuration
	output hscfg_pkg::hscfg_port_cfg_t     port_cfg_o,
	// Upstream pin mapping
	input  wire logic                      up_dplus_i,
	input  wire logic                      up_dminus_i,
	output logic                           up_dp_pin_o,
	output logic                           up_dm_pin_o
);
	logic [7:0] serial_string_bytes [hscfg_pkg::SERIAL_BYTES];
	logic [7:0] battery_charge_enable;
	logic [7:0] upstream_drive_boost;
	logic [7:0] downstream_drive_boost;
	logic [7:0] port_pin_swap;
	logic [7:0] next_rdata;
	logic       in_serial;
	logic [5:0] serial_idx;
	logic [1:0] dp_pair;
	logic [1:0] dm_pair;

	always_comb begin
		in_serial  = (req_i.addr >= hscfg_pkg::SERIAL_FIRST_OFS)
			&& (req_i.addr <= hscfg_pkg::SERIAL_LAST_OFS);
		serial_idx = 6'(req_i.addr - hscfg_pkg::SERIAL_FIRST_OFS);
	end

	// Characters are stored as consecutive low then high bytes.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < hscfg_pkg::SERIAL_BYTES; i++) begin
				serial_string_bytes[i] <= hscfg_pkg::REG_RESET_VAL;
			end
		end else if (req_i.wr && in_serial) begin
			serial_string_bytes[serial_idx] <= req_i.wdata;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			battery_charge_enable  <= hscfg_pkg::REG_RESET_VAL;
			upstream_drive_boost   <= hscfg_pkg::REG_RESET_VAL;
			downstream_drive_boost <= hscfg_pkg::REG_RESET_VAL;
			port_pin_swap          <= hscfg_pkg::REG_RESET_VAL;
		end else if (req_i.wr) begin
			if (req_i.addr == hscfg_pkg::CHARGE_EN_OFS) begin
				battery_charge_enable <= req_i.wdata & hscfg_pkg::CHARGE_EN_MASK;
			end else if (req_i.addr == hscfg_pkg::UP_BOOST_OFS) begin
				upstream_drive_boost <= req_i.wdata & hscfg_pkg::UP_BOOST_MASK;
			end else if (req_i.addr == hscfg_pkg::DN_BOOST_OFS) begin
				downstream_drive_boost <= req_i.wdata & hscfg_pkg::DN_BOOST_MASK;
			end else if (req_i.addr == hscfg_pkg::PIN_SWAP_OFS) begin
				port_pin_swap <= req_i.wdata & hscfg_pkg::PIN_SWAP_MASK;
			end
		end
	end

	// Unmapped addresses read as zero.
	always_comb begin
		next_rdata = 8'h00;
		if (in_serial) begin
			next_rdata = serial_string_bytes[serial_idx];
		end else if (req_i.addr == hscfg_pkg::CHARGE_EN_OFS) begin
			next_rdata = battery_charge_enable;
		end else if (req_i.addr == hscfg_pkg::UP_BOOST_OFS) begin
			next_rdata = upstream_drive_boost;
		end else if (req_i.addr == hscfg_pkg::DN_BOOST_OFS) begin
			next_rdata = downstream_drive_boost;
		end else if (req_i.addr == hscfg_pkg::PIN_SWAP_OFS) begin
			next_rdata = port_pin_swap;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			rdata_o  <= 8'h00;
			rvalid_o <= 1'b0;
		end else begin
			rdata_o  <= req_i.rd ? next_rdata : 8'h00;
			rvalid_o <= req_i.rd;
		end
	end

	// Out-of-range string indices return zero.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			str_byte_o <= 8'h00;
		end else if (str_idx_i < 6'(hscfg_pkg::SERIAL_BYTES)) begin
			str_byte_o <= serial_string_bytes[str_idx_i];
		end else begin
			str_byte_o <= 8'h00;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			port_cfg_o <= '0;
		end else begin
			port_cfg_o.upstream_boost_code <= hscfg_pkg::hscfg_boost_t'(
				upstream_drive_boost[hscfg_pkg::UP_BOOST_LSB +: 2]);
			port_cfg_o.port_one_boost_code <= hscfg_pkg::hscfg_boost_t'(
				downstream_drive_boost[hscfg_pkg::BOOST_P1_LSB +: 2]);
			port_cfg_o.port_two_boost_code <= hscfg_pkg::hscfg_boost_t'(
				downstream_drive_boost[hscfg_pkg::BOOST_P2_LSB +: 2]);
			port_cfg_o.charge_en <= {battery_charge_enable[hscfg_pkg::CHARGE_P2_BIT],
				battery_charge_enable[hscfg_pkg::CHARGE_P1_BIT]};
			port_cfg_o.swap <= {port_pin_swap[hscfg_pkg::SWAP_P2_BIT],
				port_pin_swap[hscfg_pkg::SWAP_P1_BIT],
				port_pin_swap[hscfg_pkg::SWAP_UP_BIT]};
		end
	end

	// Pin inputs come from the transceiver domain and are synchronised first.
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			dp_pair <= 2'b00;
			dm_pair <= 2'b00;
		end else begin
			dp_pair <= {dp_pair[0], up_dplus_i};
			dm_pair <= {dm_pair[0], up_dminus_i};
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			up_dp_pin_o <= 1'b0;
			up_dm_pin_o <= 1'b0;
		end else if (port_pin_swap[hscfg_pkg::SWAP_UP_BIT]) begin
			up_dp_pin_o <= dm_pair[1];
			up_dm_pin_o <= dp_pair[1];
		end else begin
			up_dp_pin_o <= dp_pair[1];
			up_dm_pin_o <= dm_pair[1];
		end
	end
endmodule

//--- sim/hscfg_regs_monitor.sv
// Assertions on the configuration register bank ports.
// Assumes binding to hscfg_regs with one clock domain.
`timescale 1ns/1ps
module hscfg_regs_monitor (
	input wire logic                       sys_clk_i,
	input wire logic                       rst_i,
	input wire hscfg_pkg::hscfg_req_t      req_i,
	input wire logic [7:0]                 rdata_o,
	input wire logic                       rvalid_o,
	input wire logic [5:0]                 str_idx_i,
	input wire logic [7:0]                 str_byte_o,
	input wire hscfg_pkg::hscfg_port_cfg_t port_cfg_o,
	input wire logic                       up_dplus_i,
	input wire logic                       up_dminus_i,
	input wire logic                       up_dp_pin_o,
	input wire logic                       up_dm_pin_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_wr(logic [7:0] a);
		req_i.wr && req_i.addr == a;
	endsequence
	a_str_out_range: assert property (str_idx_i > 6'h3D |=> str_byte_o == 8'h00)
		else $error("serial byte not zero");
	a_up_boost_fwd: assert property (s_wr(8'hF6)
		|=> ##1 port_cfg_o.upstream_boost_code == $past(req_i.wdata[1:0], 2)) else $error("up");
	a_p2_boost_fwd: assert property (s_wr(8'hF8)
		|=> ##1 port_cfg_o.port_two_boost_code == $past(req_i.wdata[3:2], 2)) else $error("p2");
	a_p1_boost_fwd: assert property (s_wr(8'hF8)
		|=> ##1 port_cfg_o.port_one_boost_code == $past(req_i.wdata[1:0], 2)) else $error("p1");
	a_charge_en_fwd: assert property (s_wr(8'hD0)
		|=> ##1 port_cfg_o.charge_en == $past(req_i.wdata[2:1], 2)) else $error("charge");
	a_swap_fwd: assert property (s_wr(8'hFA)
		|=> ##1 port_cfg_o.swap == $past(req_i.wdata[2:0], 2)) else $error("swap");
	a_swap_rsvd_zero: assert property (rvalid_o && $past(req_i.addr) == 8'hFA
		|-> rdata_o[7:3] == 5'h00) else $error("reserved bits set");
	a_pin_map: assert property ($stable(port_cfg_o.swap[0]) &&
		$past(port_cfg_o.swap[0], 3) == port_cfg_o.swap[0] |-> up_dp_pin_o ==
		(port_cfg_o.swap[0] ? $past(up_dminus_i, 3) : $past(up_dplus_i, 3))) else $error("pin");
endmodule
bind hscfg_regs hscfg_regs_monitor u_mon (.sys_clk_i, .rst_i, .req_i, .rdata_o, .rvalid_o,
	.str_idx_i, .str_byte_o, .port_cfg_o, .up_dplus_i, .up_dminus_i, .up_dp_pin_o, .up_dm_pin_o);

//--- sim/testbench.sv
// Self-checking bench for the configuration register bank.
// Assumes the package is compiled first and the checker is bound.
`timescale 1ns/1ps
module testbench;
	logic                       sys_clk_i = 1'b0;
	logic                       rst_i = 1'b1;
	hscfg_pkg::hscfg_req_t      req_i = '0;
	logic [7:0]                 rdata_o;
	logic                       rvalid_o;
	logic [5:0]                 str_idx_i = 6'h00;
	logic [7:0]                 str_byte_o;
	hscfg_pkg::hscfg_port_cfg_t port_cfg_o;
	logic                       up_dplus_i = 1'b0;
	logic                       up_dminus_i = 1'b0;
	logic                       up_dp_pin_o;
	logic                       up_dm_pin_o;
	int                         num_errors = 0;
	int                         n_checks = 0;
	int                         cyc = 0;
	logic [7:0]                 ofs [5] = '{8'h92, 8'hD0, 8'hF6, 8'hF8, 8'hFA};
	logic [7:0]                 msk [5] = '{8'hFF, 8'h06, 8'h03, 8'h0F, 8'h07};
	`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
		$display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
	always #25 sys_clk_i = ~sys_clk_i;
	hscfg_regs DUT (.sys_clk_i, .rst_i, .req_i, .rdata_o, .rvalid_o, .str_idx_i, .str_byte_o,
		.port_cfg_o, .up_dplus_i, .up_dminus_i, .up_dp_pin_o, .up_dm_pin_o);
	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			test_done();
		end
	end
	task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic w);
		@(posedge sys_clk_i) req_i <= {a, d, w, ~w};
		@(posedge sys_clk_i) req_i <= '0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		acc(a, 8'h00, 1'b0);
		`CHK(rvalid_o, 1'b1)
		`CHK(rdata_o, e)
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk_i);
		#1;
	endtask
	initial begin
		repeat (16) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 5; i++) rd(ofs[i], 8'h00);
		for (int i = 0; i < 5; i++) begin
			acc(ofs[i], 8'hFF, 1'b1);
			rd(ofs[i], msk[i]);
		end
		`CHK(port_cfg_o, 11'h7FF)
		rd(8'hD1, 8'h00);
		$display("test masks done");
		for (int c = 0; c < 4; c++) begin
			acc(8'hF6, 8'(c), 1'b1);
			acc(8'hF8, 8'(c * 5), 1'b1);
			settle(1);
			`CHK(port_cfg_o[10:5], {3{c[1:0]}})
		end
		$display("test boost codes done");
		acc(8'hD0, 8'h02, 1'b1);
		acc(8'hFA, 8'h03, 1'b1);
		settle(1);
		`CHK(port_cfg_o[4:0], 5'h0B)
		@(posedge sys_clk_i) up_dplus_i <= 1'b1;
		settle(4);
		`CHK({up_dp_pin_o, up_dm_pin_o}, 2'b01)
		acc(8'hFA, 8'h00, 1'b1);
		settle(4);
		`CHK({up_dp_pin_o, up_dm_pin_o}, 2'b10)
		$display("test pin swap done");
		acc(8'h92, 8'h41, 1'b1);
		acc(8'h93, 8'h20, 1'b1);
		acc(8'hCF, 8'h7E, 1'b1);
		rd(8'h93, 8'h20);
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk_i) str_idx_i <= 6'({8'd0, 8'd1, 8'd61, 8'd62} >> (24 - 8 * i));
			settle(1);
			`CHK(str_byte_o, 8'({8'h41, 8'h20, 8'h7E, 8'h00} >> (24 - 8 * i)))
		end
		$display("test serial string done");
		test_done();
	end
endmodule
